// >>> logic/pric_pkg.sv
// Constants, register map and state encoding of the prioritized interrupt controller
package pric_pkg;
  localparam int DW = 16;
  localparam int AW = 5;

  localparam logic [AW-1:0] OFS_FLAGS0  = 5'h00;
  localparam logic [AW-1:0] OFS_EN0     = 5'h03;
  localparam logic [AW-1:0] OFS_PRIO0   = 5'h06;
  localparam logic [AW-1:0] OFS_PRIO11  = 5'h11;
  localparam logic [AW-1:0] OFS_CTRL1   = 5'h12;
  localparam logic [AW-1:0] OFS_CTRL2   = 5'h13;
  localparam logic [AW-1:0] OFS_CORECTL = 5'h14;
  localparam logic [AW-1:0] OFS_STATUS  = 5'h15;

  localparam int NEST_DIS_BIT = 15;
  localparam int ALT_TBL_BIT  = 15;
  localparam int TEMPORARY_IRQ_DISABLE_BIT     = 14;
  localparam int IPL3_BIT     = 3;
  localparam int IPL_LO_POS   = 5;
  localparam int NUM_TRAPS    = 4;
  localparam int NUM_EXT      = 3;
  localparam int ADDR_ERR_TRAP = 2;
  localparam int EXT0_SRC     = 0;
  localparam int EXT1_SRC     = 16;
  localparam int EXT2_SRC     = 23;

  // Sources that exist; the remaining flag and enable bits read zero and never request
  localparam logic [47:0] IMPL_MASK = 48'h0980_03FF_FFFF;
  // Fixed trap levels, trap 3 in the top nibble
  localparam logic [15:0] TRAP_LVLS = 16'hEDCB;

  localparam logic [23:0] IVT_BASE    = 24'h000004;
  localparam logic [23:0] ALTERNATE_VECTOR_TABLE_BASE   = 24'h000084;
  localparam logic [23:0] VEC_LAST    = 24'h0000FE;
  localparam logic [7:0]  IRQ_VEC_OFS = 8'h08;

  localparam logic [3:0]  TEMPORARY_IRQ_DISABLE_MAX_LVL = 4'h6;
  localparam logic [3:0]  IPL_RST      = 4'h0;
  localparam logic [2:0]  PRIO_RST     = 3'h4;
  localparam logic [DW-1:0] CTRL_RST   = 16'h0000;

  typedef enum logic [2:0] {
    PRIC_IDLE  = 3'b001,
    PRIC_FETCH = 3'b010,
    PRIC_LOAD  = 3'b100
  } pric_state_t;
endpackage

// >>> logic/pric_top.sv
// Prioritized interrupt controller: flags, enables, arbitration and vector load
//
// Notes on behaviour
// R01: Twenty-nine interrupt sources and four traps share one priority arbitration.
// R02: Each source flag is set by hardware and cleared only by software write.
// R03: Flags set on their condition whatever the enable bit says.
// R04: A source requests service only while its own enable bit is set.
// R05: Each source has a software priority; 7 highest, 1 lowest maskable.
// R06: Priority 0 means the source is never serviced, like disabled.
// R07: Priority fields use low 3 bits of each nibble; nibble top reads 0.
// R08: Cpu priority is 4 bits: bit 3 in core control, rest in status.
// R09: With nesting disabled no new interrupt is taken during another's service.
// R10: With nesting disabled software cannot write the cpu priority bits.
// R11: Temporary disable blocks levels 6 and below; bit 14 of the second control register set meanwhile.
// R12: Equal priority ties go to the earlier vector table position.
// R13: Natural order runs from number 0 highest downwards; equals interrupt number.
// R14: Service loads the pc with the 24-bit word from the source's vector.
// R15: The vector passes from program data bus through a 24-bit pc mux.
// R16: Instruction fetch from vector space raises the address error trap.
// R17: Vector table starts at 0x000004; a control bit selects the alternate at 0x000084.
// R18: Second control register sets external edge behaviour and table choice.
// R19: First control register holds trap control and status flags.
// R20: Software should clear a flag before enabling its source.
// R21: Traps sit at fixed levels 11 to 14, so priority bit 3 is set.
// R22: Cpu priority 7 blocks all maskable interrupts while traps still run.
// R23: A request is taken only when above the current cpu priority.
`timescale 1ns/100ps
module pric_top
  import pric_pkg::*;
#(
  parameter int NUM_SRC = 48,
  parameter int TEMPORARY_IRQ_DISABLE_W  = 14
) (
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  input  wire logic [pric_pkg::AW-1:0] reg_addr,
  input  wire logic [pric_pkg::DW-1:0] reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [pric_pkg::DW-1:0]   reg_rdata,
  input  wire logic [NUM_SRC-1:0]   periph_irq,
  input  wire logic [pric_pkg::NUM_EXT-1:0] ext_int,
  input  wire logic [pric_pkg::NUM_TRAPS-1:0] trap_req,
  input  wire logic                 core_ready,
  input  wire logic                 irq_return,
  input  wire logic [3:0]           ret_ipl,
  input  wire logic                 temporary_irq_disable_start,
  input  wire logic [TEMPORARY_IRQ_DISABLE_W-1:0]    temporary_irq_disable_count,
  input  wire logic                 instr_retire,
  input  wire logic                 fetch_valid,
  input  wire logic [23:0]          fetch_addr,
  input  wire logic [23:0]          pm_data,
  output logic                      irq_pending,
  output logic                      vec_rd,
  output logic [23:0]               vec_addr,
  output logic                      pc_load_stb,
  output logic [23:0]               pc_load_val,
  output logic [3:0]                cpu_priority_level,
  output logic                      temporary_irq_disable_active
);
  import pric_pkg::*;

  localparam int NREG = 3;
  localparam int SW   = $clog2(NUM_SRC);

  logic [NUM_SRC-1:0]        flags_q;
  logic [NUM_SRC-1:0]        enables_q;
  logic [NUM_SRC-1:0][2:0]   prio_q;
  logic [NUM_TRAPS-1:0]      trap_q;
  logic                      nest_dis_q;
  logic                      alt_tbl_q;
  logic [NUM_EXT-1:0]        ext_pol_q;
  logic [3:0]                ipl_q;
  logic [3:0]                depth_q;
  logic [TEMPORARY_IRQ_DISABLE_W-1:0]         temporary_irq_disable_cnt_q;
  pric_state_t               state_q;
  logic [DW-1:0]             rdata_q;
  logic                      vec_rd_q;
  logic [23:0]               vec_addr_q;
  logic                      pc_stb_q;
  logic [23:0]               pc_val_q;
  logic [NUM_EXT-1:0]        s1_q;
  logic [NUM_EXT-1:0]        s2_q;
  logic [NUM_EXT-1:0]        s3_q;
  logic [NUM_EXT-1:0]        ext_lvl_q;

  logic [NUM_EXT-1:0]        ext_evt;
  logic [NUM_SRC-1:0]        src_set;
  logic [NUM_SRC-1:0]        elig;
  logic [NUM_TRAPS-1:0]      trap_set;
  logic                      vec_fetch_err;
  logic [3:0]                best_p;
  logic [SW-1:0]             best_i;
  logic                      best_v;
  logic [3:0]                trap_p;
  logic [7:0]                trap_i;
  logic                      trap_ok;
  logic                      irq_ok;
  logic                      take;
  logic [3:0]                win_lvl;
  logic [7:0]                win_vec;
  logic [DW-1:0]             rd_val;

  // External pins: three stages, a change counts once stages two and three agree
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s1_q      <= '0;
      s2_q      <= '0;
      s3_q      <= '0;
      ext_lvl_q <= '0;
    end else begin
      s1_q <= ext_int;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int e = 0; e < NUM_EXT; e++) begin
        if (s2_q[e] == s3_q[e]) begin
          ext_lvl_q[e] <= s3_q[e];
        end
      end
    end
  end

  // Polarity 0 takes a rising edge, 1 a falling edge
  always_comb begin
    for (int e = 0; e < NUM_EXT; e++) begin
      ext_evt[e] = (s2_q[e] == s3_q[e]) && (s3_q[e] != ext_lvl_q[e]) && (s3_q[e] != ext_pol_q[e]); // R18
    end
  end

  always_comb begin
    src_set = periph_irq;
    src_set[EXT0_SRC] = periph_irq[EXT0_SRC] | ext_evt[0];
    src_set[EXT1_SRC] = periph_irq[EXT1_SRC] | ext_evt[1];
    src_set[EXT2_SRC] = periph_irq[EXT2_SRC] | ext_evt[2];
    src_set = src_set & IMPL_MASK[NUM_SRC-1:0];
  end

  assign vec_fetch_err = fetch_valid && (fetch_addr >= IVT_BASE) && (fetch_addr <= VEC_LAST); // R16

  always_comb begin
    trap_set = trap_req;
    trap_set[ADDR_ERR_TRAP] = trap_req[ADDR_ERR_TRAP] | vec_fetch_err; // R16
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= '0;
    end else begin
      for (int r = 0; r < NREG; r++) begin
        for (int b = 0; b < DW; b++) begin
          if (r * DW + b < NUM_SRC) begin
            if (reg_wr && int'(reg_addr) == int'(OFS_FLAGS0) + r) begin
              flags_q[r*DW+b] <= (reg_wdata[b] & IMPL_MASK[r*DW+b]) | src_set[r*DW+b]; // R02
            end else begin
              flags_q[r*DW+b] <= flags_q[r*DW+b] | src_set[r*DW+b]; // R03
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      enables_q <= '0;
    end else begin
      for (int r = 0; r < NREG; r++) begin
        for (int b = 0; b < DW; b++) begin
          if (r * DW + b < NUM_SRC && reg_wr && int'(reg_addr) == int'(OFS_EN0) + r) begin
            enables_q[r*DW+b] <= reg_wdata[b] & IMPL_MASK[r*DW+b]; // R04
          end
        end
      end
    end
  end

  // Four sources per register, one nibble each
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prio_q <= {NUM_SRC{PRIO_RST}};
    end else begin
      for (int s = 0; s < NUM_SRC; s++) begin
        if (reg_wr && int'(reg_addr) == int'(OFS_PRIO0) + s / 4) begin
          prio_q[s] <= reg_wdata[(s%4)*4 +: 3]; // R07
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      trap_q     <= '0;
      nest_dis_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == OFS_CTRL1) begin
        trap_q     <= reg_wdata[NUM_TRAPS-1:0] | trap_set; // R19
        nest_dis_q <= reg_wdata[NEST_DIS_BIT];
      end else begin
        trap_q <= trap_q | trap_set; // R19
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      alt_tbl_q <= 1'b0;
      ext_pol_q <= '0;
    end else if (reg_wr && reg_addr == OFS_CTRL2) begin
      alt_tbl_q <= reg_wdata[ALT_TBL_BIT]; // R17
      ext_pol_q <= reg_wdata[NUM_EXT-1:0]; // R18
    end
  end

  // Temporary disable counts retired instructions down to zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      temporary_irq_disable_cnt_q <= '0;
    end else if (temporary_irq_disable_start) begin
      temporary_irq_disable_cnt_q <= temporary_irq_disable_count;
    end else if (instr_retire && temporary_irq_disable_cnt_q != '0) begin
      temporary_irq_disable_cnt_q <= temporary_irq_disable_cnt_q - 1'b1;
    end
  end

  assign temporary_irq_disable_active = (temporary_irq_disable_cnt_q != '0); // R11

  // Highest level wins; strict compare keeps the lowest number on a tie
  always_comb begin
    best_p = '0;
    best_i = '0;
    best_v = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      elig[i] = flags_q[i] & enables_q[i] & (prio_q[i] != 3'h0); // R04 R06
      if (elig[i] && {1'b0, prio_q[i]} > best_p) begin // R05 R12 R13
        best_p = {1'b0, prio_q[i]};
        best_i = SW'(i);
        best_v = 1'b1;
      end
    end
  end

  always_comb begin
    trap_p = '0;
    trap_i = '0;
    for (int t = 0; t < NUM_TRAPS; t++) begin
      if (trap_q[t] && TRAP_LVLS[t*4 +: 4] > trap_p) begin // R21
        trap_p = TRAP_LVLS[t*4 +: 4];
        trap_i = 8'(t);
      end
    end
  end

  // Traps nest freely; maskable requests see every block
  assign trap_ok = (trap_q != '0) && (trap_p > ipl_q); // R01 R23
  assign irq_ok  = best_v && (best_p > ipl_q) // R22 R23
                   && !(nest_dis_q && depth_q != 4'h0) // R09
                   && !(temporary_irq_disable_active && best_p <= TEMPORARY_IRQ_DISABLE_MAX_LVL); // R11
  assign irq_pending = trap_ok || irq_ok; // R01
  assign take        = irq_pending && core_ready && (state_q == PRIC_IDLE);
  assign win_lvl     = trap_ok ? trap_p : best_p;
  assign win_vec     = trap_ok ? trap_i : (8'(best_i) + IRQ_VEC_OFS);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= PRIC_IDLE;
      vec_rd_q   <= 1'b0;
      vec_addr_q <= '0;
      pc_stb_q   <= 1'b0;
      pc_val_q   <= '0;
    end else begin
      vec_rd_q <= 1'b0;
      pc_stb_q <= 1'b0;
      unique case (state_q)
        PRIC_IDLE: begin
          if (take) begin
            vec_rd_q   <= 1'b1;
            vec_addr_q <= (alt_tbl_q ? ALTERNATE_VECTOR_TABLE_BASE : IVT_BASE) + {15'h0000, win_vec, 1'b0}; // R14 R17
            state_q    <= PRIC_FETCH;
          end
        end
        PRIC_FETCH: begin
          state_q <= PRIC_LOAD;
        end
        PRIC_LOAD: begin
          pc_val_q <= pm_data; // R15
          pc_stb_q <= 1'b1; // R14
          state_q  <= PRIC_IDLE;
        end
      endcase
    end
  end

  // Write to the priority bits is dropped while nesting is disabled
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ipl_q <= IPL_RST;
    end else if (take) begin
      ipl_q <= win_lvl; // R21
    end else if (irq_return) begin
      ipl_q <= ret_ipl;
    end else if (reg_wr && !nest_dis_q && reg_addr == OFS_CORECTL) begin // R10
      ipl_q[3] <= reg_wdata[IPL3_BIT]; // R08
    end else if (reg_wr && !nest_dis_q && reg_addr == OFS_STATUS) begin // R10
      ipl_q[2:0] <= reg_wdata[IPL_LO_POS +: 3]; // R08
    end
  end

  // Service depth, saturating, so nesting can be judged
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      depth_q <= '0;
    end else if (take && depth_q != 4'hF) begin
      depth_q <= depth_q + 1'b1;
    end else if (!take && irq_return && depth_q != 4'h0) begin
      depth_q <= depth_q - 1'b1;
    end
  end

  always_comb begin
    rd_val = '0;
    for (int r = 0; r < NREG; r++) begin
      for (int b = 0; b < DW; b++) begin
        if (r * DW + b < NUM_SRC) begin
          if (int'(reg_addr) == int'(OFS_FLAGS0) + r) begin
            rd_val[b] = flags_q[r*DW+b];
          end
          if (int'(reg_addr) == int'(OFS_EN0) + r) begin
            rd_val[b] = enables_q[r*DW+b];
          end
        end
      end
    end
    if (reg_addr >= OFS_PRIO0 && reg_addr <= OFS_PRIO11) begin
      for (int j = 0; j < 4; j++) begin
        if ((int'(reg_addr) - int'(OFS_PRIO0)) * 4 + j < NUM_SRC) begin
          rd_val[j*4 +: 3] = prio_q[(int'(reg_addr) - int'(OFS_PRIO0)) * 4 + j]; // R07
        end
      end
    end
    if (reg_addr == OFS_CTRL1) begin
      rd_val[NEST_DIS_BIT]    = nest_dis_q;
      rd_val[NUM_TRAPS-1:0]   = trap_q;
    end
    if (reg_addr == OFS_CTRL2) begin
      rd_val[ALT_TBL_BIT]     = alt_tbl_q;
      rd_val[TEMPORARY_IRQ_DISABLE_BIT]        = temporary_irq_disable_active; // R11
      rd_val[NUM_EXT-1:0]     = ext_pol_q;
    end
    if (reg_addr == OFS_CORECTL) begin
      rd_val[IPL3_BIT]        = ipl_q[3]; // R08
    end
    if (reg_addr == OFS_STATUS) begin
      rd_val[IPL_LO_POS +: 3] = ipl_q[2:0]; // R08
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_rd ? rd_val : '0;
    end
  end

  assign reg_rdata          = rdata_q;
  assign vec_rd             = vec_rd_q;
  assign vec_addr           = vec_addr_q;
  assign pc_load_stb        = pc_stb_q;
  assign pc_load_val        = pc_val_q;
  assign cpu_priority_level = ipl_q;
endmodule

// >>> sim/pric_core_model.sv
// Core side model: boundary ready level and program memory answer to vector reads
`timescale 1ns/100ps
module pric_core_model (
  input wire logic         clock,
  input wire logic         rst_b,
  input wire logic         slow,
  input wire logic         vec_rd,
  input wire logic [23:0]  vec_addr,
  output logic             core_ready,
  output logic [23:0]      pm_data
);
  // Slow mode keeps the core off boundaries to delay acceptance
  assign core_ready = rst_b && !slow;
  // Bus valid only in the answer cycle; inverted junk otherwise
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pm_data <= 24'h000000;
    end else begin
      pm_data <= vec_rd ? {8'h5A, vec_addr[15:0]} : ~pm_data;
    end
  end
endmodule

// >>> sim/pric_top_props.sv
// Checker of service timing, vector range and level rules of the interrupt controller
`timescale 1ns/100ps
module pric_top_props
  import pric_pkg::*;
#(
  parameter int TEMPORARY_IRQ_DISABLE_W = 14
) (
  input wire logic              clock,
  input wire logic              rst_b,
  input wire logic              vec_rd,
  input wire logic [23:0]       vec_addr,
  input wire logic [23:0]       pm_data,
  input wire logic              pc_load_stb,
  input wire logic [23:0]       pc_load_val,
  input wire logic [3:0]        cpu_priority_level,
  input wire logic              temporary_irq_disable_active,
  input wire logic              temporary_irq_disable_start,
  input wire logic [TEMPORARY_IRQ_DISABLE_W-1:0] temporary_irq_disable_count,
  input wire logic              instr_retire
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_load_timing: assert property (vec_rd |-> ##2 pc_load_stb)
    else $error("pc load not two cycles after vector read");
  a_load_from_bus: assert property (pc_load_stb |-> pc_load_val == $past(pm_data))
    else $error("pc load value differs from program data bus");
  a_vec_in_space: assert property (vec_rd |-> vec_addr >= 24'h000004 && vec_addr <= 24'h0000FE && !vec_addr[0])
    else $error("vector address outside vector space");
  a_busy_gap: assert property (vec_rd |=> !vec_rd [*2])
    else $error("second take while service still busy");
  a_take_above: assert property (vec_rd |-> cpu_priority_level > $past(cpu_priority_level))
    else $error("take not above previous cpu level");
  a_temporary_irq_disable_caps_level: assert property (vec_rd && $past(temporary_irq_disable_active) |-> cpu_priority_level > 4'h6)
    else $error("level six or below taken during temporary disable");
  a_temporary_irq_disable_arms: assert property (temporary_irq_disable_start && temporary_irq_disable_count != '0 && !instr_retire |=> temporary_irq_disable_active)
    else $error("temporary disable not active after start");
  a_trap_level: assert property (vec_rd && vec_addr[6:0] < 7'h0C |-> cpu_priority_level[3])
    else $error("trap taken without top level bit");
endmodule

// >>> sim/test_prioritized_interrupt_controller.sv
// Self-checking bench of the interrupt controller with a core model
`timescale 1ns/100ps
module test_prioritized_interrupt_controller;
  import pric_pkg::*;
  logic clock, rst_b, reg_wr, reg_rd, core_ready, irq_return, temporary_irq_disable_start, instr_retire, fetch_valid, slow;
  logic irq_pending, vec_rd, pc_load_stb, temporary_irq_disable_active;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata;
  logic [47:0] periph_irq;
  logic [2:0] ext_int;
  logic [3:0] trap_req, ret_ipl, cpu_priority_level;
  logic [13:0] temporary_irq_disable_count;
  logic [23:0] fetch_addr, pm_data, vec_addr, pc_load_val;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;

  pric_top dut_u (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .periph_irq, .ext_int,
    .trap_req, .core_ready, .irq_return, .ret_ipl, .temporary_irq_disable_start, .temporary_irq_disable_count, .instr_retire, .fetch_valid,
    .fetch_addr, .pm_data, .irq_pending, .vec_rd, .vec_addr, .pc_load_stb, .pc_load_val, .cpu_priority_level,
    .temporary_irq_disable_active);
  pric_core_model core_u (.clock, .rst_b, .slow, .vec_rd, .vec_addr, .core_ready, .pm_data);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Whole run needs a few hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [AW-1:0] a, logic [DW-1:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [AW-1:0] a, logic [DW-1:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk("reg_rdata", 24'(exp), 24'(reg_rdata));
  endtask

  task automatic pulse(logic [47:0] m);
    @(posedge clock);
    periph_irq <= m;
    @(posedge clock);
    periph_irq <= '0;
  endtask

  task automatic ret(logic [3:0] v);
    @(posedge clock);
    irq_return <= 1'b1;
    ret_ipl <= v;
    @(posedge clock);
    irq_return <= 1'b0;
  endtask

  task automatic fetch(logic [23:0] a);
    @(posedge clock);
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    @(posedge clock);
    fetch_valid <= 1'b0;
  endtask

  task automatic idle(int n);
    repeat (n) @(negedge clock);
    chk("irq_pending", 24'h0, 24'(irq_pending));
  endtask

  // Waits for a take, then judges vector, level and pc load
  task automatic svc(logic [23:0] a, logic [3:0] l);
    int i;
    i = 0;
    while (vec_rd !== 1'b1 && i < 40) begin
      @(negedge clock);
      i++;
    end
    chk("vec_rd", 24'h1, 24'(vec_rd));
    chk("vec_addr", a, vec_addr);
    chk("cpu_priority_level", 24'(l), 24'(cpu_priority_level));
    repeat (2) @(negedge clock);
    chk("pc_load_stb", 24'h1, 24'(pc_load_stb));
    chk("pc_load_val", {8'h5A, a[15:0]}, pc_load_val);
  endtask

  task automatic t_regs();
    rd(OFS_PRIO0, 16'h4444);
    wr(OFS_PRIO0, 16'hFFFF);
    rd(OFS_PRIO0, 16'h7777);
    rd(5'h1F, 16'h0000);
    rd(OFS_CTRL1, 16'h0000);
  endtask

  task automatic t_flags();
    pulse(48'h0000_4000_0020);
    rd(OFS_FLAGS0, 16'h0020);
    rd(OFS_FLAGS0 + 5'h1, 16'h0000);
    idle(2);
    wr(OFS_FLAGS0, 16'h0000);
    rd(OFS_FLAGS0, 16'h0000);
    @(posedge clock);
    ext_int <= 3'b001;
    repeat (6) @(posedge clock);
    rd(OFS_FLAGS0, 16'h0001);
    wr(OFS_FLAGS0, 16'h0000);
    // Falling polarity: only the drop of the held-high pin may set the flag
    wr(OFS_CTRL2, 16'h0001);
    @(posedge clock);
    ext_int <= 3'b000;
    repeat (6) @(posedge clock);
    rd(OFS_FLAGS0, 16'h0001);
    wr(OFS_FLAGS0, 16'h0000);
    wr(OFS_CTRL2, 16'h0000);
  endtask

  task automatic t_order();
    wr(OFS_PRIO0, 16'h5000);
    wr(OFS_PRIO0 + 5'h1, 16'h5000);
    wr(OFS_PRIO0 + 5'h2, 16'h0070);
    wr(OFS_FLAGS0, 16'h0000);
    wr(OFS_EN0, 16'h028C);
    pulse(48'h8C);
    svc(24'h1A, 4'h5);
    idle(6);
    pulse(48'h200);
    svc(24'h26, 4'h7);
    wr(OFS_FLAGS0, 16'h0084);
    ret(4'h5);
    idle(4);
    ret(4'h0);
    svc(24'h22, 4'h5);
    wr(OFS_FLAGS0, 16'h0004);
    ret(4'h0);
    idle(4);
  endtask

  task automatic t_nest();
    wr(OFS_CTRL1, 16'h8000);
    pulse(48'h8);
    svc(24'h1A, 4'h5);
    pulse(48'h200);
    idle(6);
    wr(OFS_STATUS, 16'h0000);
    idle(1);
    chk("cpu_priority_level", 24'h5, 24'(cpu_priority_level));
    ret(4'h0);
    svc(24'h26, 4'h7);
    wr(OFS_FLAGS0, 16'h0000);
    wr(OFS_CTRL1, 16'h0000);
    ret(4'h0);
  endtask

  task automatic t_temporary_irq_disable();
    wr(OFS_PRIO0 + 5'h1, 16'h6000);
    @(posedge clock);
    temporary_irq_disable_start <= 1'b1;
    temporary_irq_disable_count <= 14'h0002;
    @(posedge clock);
    temporary_irq_disable_start <= 1'b0;
    rd(OFS_CTRL2, 16'h4000);
    chk("temporary_irq_disable_active", 24'h1, 24'(temporary_irq_disable_active));
    pulse(48'h80);
    idle(6);
    // Level seven still gets through while the lower one waits
    pulse(48'h200);
    svc(24'h26, 4'h7);
    wr(OFS_FLAGS0, 16'h0080);
    ret(4'h0);
    idle(4);
    repeat (2) begin
      @(posedge clock);
      instr_retire <= 1'b1;
      @(posedge clock);
      instr_retire <= 1'b0;
    end
    @(negedge clock);
    chk("temporary_irq_disable_active", 24'h0, 24'(temporary_irq_disable_active));
    svc(24'h22, 4'h6);
    wr(OFS_FLAGS0, 16'h0000);
    ret(4'h0);
  endtask

  task automatic t_trap();
    wr(OFS_STATUS, 16'h00E0);
    pulse(48'h200);
    idle(4);
    chk("cpu_priority_level", 24'h7, 24'(cpu_priority_level));
    fetch(24'h000100);
    idle(4);
    fetch(24'h000010);
    svc(24'h08, 4'hD);
    rd(OFS_CTRL1, 16'h0004);
    wr(OFS_CTRL1, 16'h0000);
    wr(OFS_FLAGS0, 16'h0000);
    ret(4'h0);
  endtask

  task automatic t_alt();
    wr(OFS_CTRL2, 16'h8000);
    @(posedge clock);
    slow <= 1'b1;
    pulse(48'h8);
    repeat (5) @(negedge clock);
    chk("vec_rd", 24'h0, 24'(vec_rd));
    chk("irq_pending", 24'h1, 24'(irq_pending));
    @(posedge clock);
    slow <= 1'b0;
    svc(24'h9A, 4'h5);
    wr(OFS_FLAGS0, 16'h0000);
  endtask

  initial begin
    rst_b = 1'b0;
    {reg_wr, reg_rd, irq_return, temporary_irq_disable_start, instr_retire, fetch_valid, slow, periph_irq, ext_int, trap_req,
      ret_ipl, temporary_irq_disable_count, fetch_addr, reg_addr, reg_wdata} = '0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    t_regs();
    t_flags();
    t_order();
    t_nest();
    t_temporary_irq_disable();
    t_trap();
    t_alt();
    finish_test();
  end
endmodule

bind pric_top pric_top_props #(.TEMPORARY_IRQ_DISABLE_W(TEMPORARY_IRQ_DISABLE_W)) props_u (.clock, .rst_b, .vec_rd, .vec_addr, .pm_data,
  .pc_load_stb, .pc_load_val, .cpu_priority_level, .temporary_irq_disable_active, .temporary_irq_disable_start, .temporary_irq_disable_count, .instr_retire);
